// [verilog/sscr_top.sv]
// Sensor system control register bank behind the serial port
//
// Function
// - Field 0x9 holds subunit in reset
// - PLL power bit zero powers down
// - PLL enable bit, resets disabled
// - PLL bypass bit, resets bypassed
// - Clock input receiver power bit, resets zero
// - Analog clock enable bit, resets off
// - Logic clock enable bit, resets off
// - Clock source select, resets to PLL
// - Conversion width select, resets 10-bit
// - General logic enable, resets off
// - Pixel core power bit, resets down
// - Column multiplexer power bit, resets down
// - Column bias enable, resets off
`timescale 1ns/1ps
`default_nettype none
module sscr_top #(
  // Arbitrary identification value
  parameter logic [15:0] IDENT = sscr_pkg::IDENT_DEFAULT
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // Serial configuration port
  input wire logic SPI_SCK,
  input wire logic SPI_SEL_N,
  input wire logic SPI_MOSI,
  output logic SPI_MISO,
  // Lock indication from the PLL
  input wire logic PLL_LOCK_IN,
  // Soft reset holds, high while held
  output logic PLL_RST_HOLD,
  output logic PLL_LOCK_RST_HOLD,
  output logic CGEN_RST_HOLD,
  output logic MUX_RST_HOLD,
  output logic AFE_RST_HOLD,
  output logic SER_RST_HOLD,
  // PLL and clock input
  output logic PLL_PWR_ON,
  output logic PLL_ENABLE,
  output logic PLL_BYPASS,
  output logic CLKIN_PWR_ON,
  // Clock generator
  output logic ANA_CLK_EN,
  output logic LOGIC_CLK_EN,
  output logic CLK_SRC_PLL,
  output logic ADC_8BIT,
  // Logic and image core
  output logic LOGIC_EN,
  output logic IMC_PWR_ON,
  output logic MUX_PWR_ON,
  output logic COLBIAS_EN,
  output logic [1:0] PART_VARIANT
);

  sscr_cfg_if cfg ();

  logic sck_s;
  logic sel_n_s;
  logic mosi_s;
  logic lock_s;
  logic miso_w;

  logic [15:0] variant_r;
  logic [15:0] pll_rst_r;
  logic [15:0] cgen_rst_r;
  logic [15:0] ana_rst_r;
  logic [15:0] pll_sup_r;
  logic [15:0] pll_rsv_r;
  logic [15:0] clkin_r;
  logic [15:0] lock_rsv_a_r;
  logic [15:0] lock_rsv_b_r;
  logic [15:0] cgen_r;
  logic [15:0] logic_r;
  logic [15:0] imc_r;
  logic lock_r;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  function automatic logic is_hold(input logic [15:0] w, input int pos);
    logic [3:0] f;
    f = w[pos +: 4];
    return f == sscr_pkg::HOLD_CODE;
  endfunction

  function automatic logic [15:0] masked(input logic [15:0] w,
                                         input logic [15:0] m);
    return w & m;
  endfunction

  function automatic logic hit(input logic [8:0] a);
    return cfg.wr_pulse && cfg.addr == a;
  endfunction

  // Pins come from outside the clock domain
  sscr_sync #(.W(3), .INIT(3'h2)) u_pin_sync (
    .clk(SYS_CLK),
    .nrst(NRST),
    .d({SPI_SCK, SPI_SEL_N, SPI_MOSI}),
    .q({sck_s, sel_n_s, mosi_s})
  );

  sscr_sync #(.W(1), .INIT(1'b0)) u_lock_sync (
    .clk(SYS_CLK),
    .nrst(NRST),
    .d(PLL_LOCK_IN),
    .q(lock_s)
  );

  sscr_spi u_spi (
    .clk(SYS_CLK),
    .nrst(NRST),
    .sck_s(sck_s),
    .sel_n_s(sel_n_s),
    .mosi_s(mosi_s),
    .miso_r(miso_w),
    .cfg(cfg.port)
  );

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      variant_r <= sscr_pkg::RST_PART_VARIANT;
    end else if (hit(sscr_pkg::A_PART_VARIANT_SELECT)) begin
      variant_r <= masked(cfg.wdata, sscr_pkg::MSK_PART_VARIANT);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      pll_rst_r <= sscr_pkg::RST_PLL_RESET;
      cgen_rst_r <= sscr_pkg::RST_CLOCKGEN_RESET;
      ana_rst_r <= sscr_pkg::RST_ANALOG_RESET;
    end else begin
      if (hit(sscr_pkg::A_PLL_RESET_CONTROL)) begin
        pll_rst_r <= masked(cfg.wdata, sscr_pkg::MSK_PLL_RESET);
      end
      if (hit(sscr_pkg::A_CLOCKGEN_RESET_CONTROL)) begin
        cgen_rst_r <= masked(cfg.wdata, sscr_pkg::MSK_CLOCKGEN_RESET);
      end
      if (hit(sscr_pkg::A_ANALOG_PATH_RESET_CONTROL)) begin
        ana_rst_r <= masked(cfg.wdata, sscr_pkg::MSK_ANALOG_RESET);
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      pll_sup_r <= sscr_pkg::RST_PLL_SUPPLY;
    end else if (hit(sscr_pkg::A_PLL_SUPPLY_CONTROL)) begin
      pll_sup_r <= masked(cfg.wdata, sscr_pkg::MSK_PLL_SUPPLY);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      clkin_r <= sscr_pkg::RST_CLOCK_INPUT;
    end else if (hit(sscr_pkg::A_CLOCK_INPUT_CONTROL)) begin
      clkin_r <= masked(cfg.wdata, sscr_pkg::MSK_CLOCK_INPUT);
    end
  end

  // Reserved words only store; they steer nothing here
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      pll_rsv_r <= sscr_pkg::RST_PLL_RESERVED;
      lock_rsv_a_r <= sscr_pkg::RST_LOCK_RESERVED_A;
      lock_rsv_b_r <= sscr_pkg::RST_LOCK_RESERVED_B;
    end else begin
      if (hit(sscr_pkg::A_PLL_RESERVED_WORD)) begin
        pll_rsv_r <= masked(cfg.wdata, sscr_pkg::MSK_PLL_RESERVED);
      end
      if (hit(sscr_pkg::A_LOCK_DETECTOR_RESERVED_A)) begin
        lock_rsv_a_r <= masked(cfg.wdata, sscr_pkg::MSK_LOCK_RESERVED_A);
      end
      if (hit(sscr_pkg::A_LOCK_DETECTOR_RESERVED_B)) begin
        lock_rsv_b_r <= masked(cfg.wdata, sscr_pkg::MSK_LOCK_RESERVED_B);
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      cgen_r <= sscr_pkg::RST_CLOCK_GEN;
    end else if (hit(sscr_pkg::A_CLOCK_GENERATOR_CONTROL)) begin
      cgen_r <= masked(cfg.wdata, sscr_pkg::MSK_CLOCK_GEN);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      logic_r <= sscr_pkg::RST_LOGIC_TOP;
    end else if (hit(sscr_pkg::A_LOGIC_TOP_CONTROL)) begin
      logic_r <= masked(cfg.wdata, sscr_pkg::MSK_LOGIC_TOP);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      imc_r <= sscr_pkg::RST_IMAGE_CORE;
    end else if (hit(sscr_pkg::A_IMAGE_CORE_POWER_CONTROL)) begin
      imc_r <= masked(cfg.wdata, sscr_pkg::MSK_IMAGE_CORE);
    end
  end

  // lock follows the synchronised PLL flag
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      lock_r <= 1'b0;
    end else begin
      lock_r <= lock_s;
    end
  end

  // identity is a constant; no write path exists
  always_comb begin
    rdata_nxt = 16'h0000;
    case (cfg.addr)
      sscr_pkg::A_CHIP_IDENTITY: rdata_nxt = IDENT;
      sscr_pkg::A_RESERVED_WORD_ONE: rdata_nxt = 16'h0000;
      sscr_pkg::A_PART_VARIANT_SELECT: rdata_nxt = variant_r;
      sscr_pkg::A_PLL_RESET_CONTROL: rdata_nxt = pll_rst_r;
      sscr_pkg::A_CLOCKGEN_RESET_CONTROL: rdata_nxt = cgen_rst_r;
      sscr_pkg::A_ANALOG_PATH_RESET_CONTROL: rdata_nxt = ana_rst_r;
      sscr_pkg::A_PLL_SUPPLY_CONTROL: rdata_nxt = pll_sup_r;
      sscr_pkg::A_PLL_RESERVED_WORD: rdata_nxt = pll_rsv_r;
      sscr_pkg::A_CLOCK_INPUT_CONTROL: rdata_nxt = clkin_r;
      sscr_pkg::A_LOCK_DETECTOR_STATUS: rdata_nxt = {15'h0000, lock_r};
      sscr_pkg::A_LOCK_DETECTOR_RESERVED_A: rdata_nxt = lock_rsv_a_r;
      sscr_pkg::A_LOCK_DETECTOR_RESERVED_B: rdata_nxt = lock_rsv_b_r;
      sscr_pkg::A_CLOCK_GENERATOR_CONTROL: rdata_nxt = cgen_r;
      sscr_pkg::A_LOGIC_TOP_CONTROL: rdata_nxt = logic_r;
      sscr_pkg::A_IMAGE_CORE_POWER_CONTROL: rdata_nxt = imc_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // Captured on the read strobe so the shifter sees a stable word
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      rdata_r <= 16'h0000;
    end else if (cfg.rd_pulse) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign cfg.rdata = rdata_r;

  // hold decode, one cycle behind the field
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      PLL_RST_HOLD <= 1'b1;
      PLL_LOCK_RST_HOLD <= 1'b1;
      CGEN_RST_HOLD <= 1'b1;
      MUX_RST_HOLD <= 1'b1;
      AFE_RST_HOLD <= 1'b1;
      SER_RST_HOLD <= 1'b1;
    end else begin
      PLL_RST_HOLD <= is_hold(pll_rst_r, sscr_pkg::F_PLL_RST);
      PLL_LOCK_RST_HOLD <= is_hold(pll_rst_r, sscr_pkg::F_PLL_LOCK_RST);
      CGEN_RST_HOLD <= is_hold(cgen_rst_r, sscr_pkg::F_CGEN_RST);
      MUX_RST_HOLD <= is_hold(ana_rst_r, sscr_pkg::F_MUX_RST);
      AFE_RST_HOLD <= is_hold(ana_rst_r, sscr_pkg::F_AFE_RST);
      SER_RST_HOLD <= is_hold(ana_rst_r, sscr_pkg::F_SER_RST);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      PLL_PWR_ON <= 1'b0;
      PLL_ENABLE <= 1'b0;
      PLL_BYPASS <= 1'b1;
      CLKIN_PWR_ON <= 1'b0;
    end else begin
      PLL_PWR_ON <= pll_sup_r[sscr_pkg::B_PLL_PWR];
      PLL_ENABLE <= pll_sup_r[sscr_pkg::B_PLL_EN];
      PLL_BYPASS <= pll_sup_r[sscr_pkg::B_PLL_BYPASS];
      CLKIN_PWR_ON <= clkin_r[sscr_pkg::B_CLKIN_PWR];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      ANA_CLK_EN <= 1'b0;
      LOGIC_CLK_EN <= 1'b0;
      CLK_SRC_PLL <= 1'b1;
      ADC_8BIT <= 1'b0;
    end else begin
      ANA_CLK_EN <= cgen_r[sscr_pkg::B_ANA_CLK];
      LOGIC_CLK_EN <= cgen_r[sscr_pkg::B_LOGIC_CLK];
      CLK_SRC_PLL <= cgen_r[sscr_pkg::B_SEL_PLL];
      ADC_8BIT <= cgen_r[sscr_pkg::B_ADC_8BIT];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      LOGIC_EN <= 1'b0;
      IMC_PWR_ON <= 1'b0;
      MUX_PWR_ON <= 1'b0;
      COLBIAS_EN <= 1'b0;
      PART_VARIANT <= 2'h0;
    end else begin
      LOGIC_EN <= logic_r[sscr_pkg::B_LOGIC_EN];
      IMC_PWR_ON <= imc_r[sscr_pkg::B_IMC_PWR];
      MUX_PWR_ON <= imc_r[sscr_pkg::B_MUX_PWR];
      COLBIAS_EN <= imc_r[sscr_pkg::B_COLBIAS];
      PART_VARIANT <= variant_r[1:0];
    end
  end

  assign SPI_MISO = miso_w;

endmodule
`default_nettype wire

// [verilog/sscr_pkg.sv]
// Constants for the sensor system control register bank
package sscr_pkg;

  // Serial frame layout: address, direction bit, data word
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int FRAME_BITS = ADDR_W + 1 + DATA_W;
  localparam int CNT_W = 5;
  localparam logic [4:0] CNT_DIR = 5'h09;
  localparam logic [4:0] CNT_LAST = 5'h19;
  localparam logic [4:0] CNT_END = 5'h1A;
  localparam logic DIR_WRITE = 1'b1;

  // Register addresses
  localparam logic [8:0] A_CHIP_IDENTITY = 9'h000;
  localparam logic [8:0] A_RESERVED_WORD_ONE = 9'h001;
  localparam logic [8:0] A_PART_VARIANT_SELECT = 9'h002;
  localparam logic [8:0] A_PLL_RESET_CONTROL = 9'h008;
  localparam logic [8:0] A_CLOCKGEN_RESET_CONTROL = 9'h009;
  localparam logic [8:0] A_ANALOG_PATH_RESET_CONTROL = 9'h00A;
  localparam logic [8:0] A_PLL_SUPPLY_CONTROL = 9'h010;
  localparam logic [8:0] A_PLL_RESERVED_WORD = 9'h011;
  localparam logic [8:0] A_CLOCK_INPUT_CONTROL = 9'h014;
  localparam logic [8:0] A_LOCK_DETECTOR_STATUS = 9'h018;
  localparam logic [8:0] A_LOCK_DETECTOR_RESERVED_A = 9'h01A;
  localparam logic [8:0] A_LOCK_DETECTOR_RESERVED_B = 9'h01B;
  localparam logic [8:0] A_CLOCK_GENERATOR_CONTROL = 9'h020;
  localparam logic [8:0] A_LOGIC_TOP_CONTROL = 9'h022;
  localparam logic [8:0] A_IMAGE_CORE_POWER_CONTROL = 9'h028;

  // Reset values
  localparam logic [15:0] RST_PART_VARIANT = 16'h0000;
  localparam logic [15:0] RST_PLL_RESET = 16'h0099;
  localparam logic [15:0] RST_CLOCKGEN_RESET = 16'h0009;
  localparam logic [15:0] RST_ANALOG_RESET = 16'h0999;
  localparam logic [15:0] RST_PLL_SUPPLY = 16'h0004;
  localparam logic [15:0] RST_PLL_RESERVED = 16'h2113;
  localparam logic [15:0] RST_CLOCK_INPUT = 16'h0000;
  localparam logic [15:0] RST_LOCK_RESERVED_A = 16'h2182;
  localparam logic [15:0] RST_LOCK_RESERVED_B = 16'h3D2D;
  localparam logic [15:0] RST_CLOCK_GEN = 16'h0004;
  localparam logic [15:0] RST_LOGIC_TOP = 16'h0000;
  localparam logic [15:0] RST_IMAGE_CORE = 16'h0000;

  // Writable bit masks; other bits read as zero
  localparam logic [15:0] MSK_PART_VARIANT = 16'h0003;
  localparam logic [15:0] MSK_PLL_RESET = 16'h00FF;
  localparam logic [15:0] MSK_CLOCKGEN_RESET = 16'h000F;
  localparam logic [15:0] MSK_ANALOG_RESET = 16'h0FFF;
  localparam logic [15:0] MSK_PLL_SUPPLY = 16'h0007;
  localparam logic [15:0] MSK_PLL_RESERVED = 16'hFFFF;
  localparam logic [15:0] MSK_CLOCK_INPUT = 16'h0701;
  localparam logic [15:0] MSK_LOCK_RESERVED_A = 16'h7FFF;
  localparam logic [15:0] MSK_LOCK_RESERVED_B = 16'hFFFF;
  localparam logic [15:0] MSK_CLOCK_GEN = 16'h7F0F;
  localparam logic [15:0] MSK_LOGIC_TOP = 16'h0001;
  localparam logic [15:0] MSK_IMAGE_CORE = 16'h0007;

  // Soft reset fields
  localparam logic [3:0] HOLD_CODE = 4'h9;
  localparam int F_PLL_RST = 0;
  localparam int F_PLL_LOCK_RST = 4;
  localparam int F_CGEN_RST = 0;
  localparam int F_MUX_RST = 0;
  localparam int F_AFE_RST = 4;
  localparam int F_SER_RST = 8;

  // Single-bit field positions
  localparam int B_PLL_PWR = 0;
  localparam int B_PLL_EN = 1;
  localparam int B_PLL_BYPASS = 2;
  localparam int B_CLKIN_PWR = 0;
  localparam int B_LOCK = 0;
  localparam int B_ANA_CLK = 0;
  localparam int B_LOGIC_CLK = 1;
  localparam int B_SEL_PLL = 2;
  localparam int B_ADC_8BIT = 3;
  localparam int B_LOGIC_EN = 0;
  localparam int B_IMC_PWR = 0;
  localparam int B_MUX_PWR = 1;
  localparam int B_COLBIAS = 2;

  // Arbitrary identification value
  localparam logic [15:0] IDENT_DEFAULT = 16'hC0DE;

endpackage

// [verilog/sscr_cfg_if.sv]
// Carrier between the serial port engine and the register file
`timescale 1ns/1ps
`default_nettype none
interface sscr_cfg_if;
  logic wr_pulse;
  logic rd_pulse;
  logic [sscr_pkg::ADDR_W-1:0] addr;
  logic [sscr_pkg::DATA_W-1:0] wdata;
  logic [sscr_pkg::DATA_W-1:0] rdata;

  modport port (
    output wr_pulse,
    output rd_pulse,
    output addr,
    output wdata,
    input rdata
  );

  modport regs (
    input wr_pulse,
    input rd_pulse,
    input addr,
    input wdata,
    output rdata
  );
endinterface
`default_nettype wire

// [verilog/sscr_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sscr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule
`default_nettype wire

// [verilog/sscr_spi.sv]
// Serial configuration port frame engine (mode 0, MSB first)
`timescale 1ns/1ps
`default_nettype none
module sscr_spi (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Synchronised pins
  input wire logic sck_s,
  input wire logic sel_n_s,
  input wire logic mosi_s,
  output logic miso_r,
  // Register side
  sscr_cfg_if.port cfg
);

  logic sck_d_r;
  logic [4:0] cnt_r;
  logic [24:0] shin_r;
  logic dir_r;
  logic load_r;
  logic [15:0] tx_r;
  logic rise;
  logic fall;

  assign rise = sck_s & ~sck_d_r;
  assign fall = ~sck_s & sck_d_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
    end
  end

  // Deselect aborts any partial frame
  always_ff @(posedge clk) begin
    if (!nrst || sel_n_s) begin
      cnt_r <= '0;
      shin_r <= '0;
    end else if (rise && cnt_r != sscr_pkg::CNT_END) begin
      cnt_r <= cnt_r + 5'h01;
      shin_r <= {shin_r[23:0], mosi_s};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dir_r <= 1'b0;
      cfg.addr <= '0;
      cfg.rd_pulse <= 1'b0;
      cfg.wr_pulse <= 1'b0;
      cfg.wdata <= '0;
    end else begin
      cfg.rd_pulse <= 1'b0;
      cfg.wr_pulse <= 1'b0;
      if (!sel_n_s && rise && cnt_r == sscr_pkg::CNT_DIR) begin
        cfg.addr <= shin_r[8:0];
        dir_r <= mosi_s;
        cfg.rd_pulse <= (mosi_s != sscr_pkg::DIR_WRITE);
      end
      // Write commits only on a complete frame
      if (!sel_n_s && rise && cnt_r == sscr_pkg::CNT_LAST &&
          dir_r == sscr_pkg::DIR_WRITE) begin
        cfg.wr_pulse <= 1'b1;
        cfg.wdata <= {shin_r[14:0], mosi_s};
      end
    end
  end

  // Readback shifts out on falling edges after the direction bit
  always_ff @(posedge clk) begin
    if (!nrst || sel_n_s) begin
      load_r <= 1'b0;
      tx_r <= '0;
      miso_r <= 1'b0;
    end else begin
      load_r <= cfg.rd_pulse;
      if (load_r) begin
        tx_r <= cfg.rdata;
      end else if (fall && dir_r != sscr_pkg::DIR_WRITE &&
                   cnt_r > sscr_pkg::CNT_DIR) begin
        miso_r <= tx_r[15];
        tx_r <= {tx_r[14:0], 1'b0};
      end
    end
  end

endmodule
`default_nettype wire

// [testbench/sscr_top_chk.sv]
// Assertion checker for the system control register bank
`timescale 1ns/1ps
`default_nettype none
module sscr_top_chk (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // Serial port
  input wire logic SPI_SEL_N,
  input wire logic SPI_MISO,
  // Soft reset holds
  input wire logic PLL_RST_HOLD,
  input wire logic PLL_LOCK_RST_HOLD,
  input wire logic CGEN_RST_HOLD,
  input wire logic MUX_RST_HOLD,
  input wire logic AFE_RST_HOLD,
  input wire logic SER_RST_HOLD,
  // Control levels
  input wire logic PLL_PWR_ON,
  input wire logic PLL_ENABLE,
  input wire logic PLL_BYPASS,
  input wire logic CLKIN_PWR_ON,
  input wire logic ANA_CLK_EN,
  input wire logic LOGIC_CLK_EN,
  input wire logic CLK_SRC_PLL,
  input wire logic ADC_8BIT,
  input wire logic LOGIC_EN,
  input wire logic IMC_PWR_ON,
  input wire logic MUX_PWR_ON,
  input wire logic COLBIAS_EN,
  input wire logic [1:0] PART_VARIANT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  wire [5:0] holds = {SER_RST_HOLD, AFE_RST_HOLD, MUX_RST_HOLD,
    CGEN_RST_HOLD, PLL_LOCK_RST_HOLD, PLL_RST_HOLD};
  wire [3:0] pll_o = {CLKIN_PWR_ON, PLL_BYPASS, PLL_ENABLE, PLL_PWR_ON};
  wire [3:0] cg_o = {ADC_8BIT, CLK_SRC_PLL, LOGIC_CLK_EN, ANA_CLK_EN};
  wire [5:0] core_o = {LOGIC_EN, COLBIAS_EN, MUX_PWR_ON, IMC_PWR_ON,
    PART_VARIANT};
  logic [3:0] idle_r;
  // Deselect length; writes land well before eight idle cycles
  always_ff @(posedge SYS_CLK) begin
    if (!NRST || !SPI_SEL_N) idle_r <= 4'h0;
    else if (idle_r != 4'hF) idle_r <= idle_r + 4'h1;
  end
  property p_rst_holds;
    $rose(NRST) |-> holds == 6'h3F;
  endproperty
  a_rst_holds: assert property (p_rst_holds)
    else $error("holds not set after reset");
  property p_hold_stays;
    $rose(NRST) |-> PLL_RST_HOLD [*8];
  endproperty
  a_hold_stays: assert property (p_hold_stays)
    else $error("pll hold dropped without a write");
  property p_rst_pll;
    !$past(NRST) |-> pll_o == 4'h4;
  endproperty
  a_rst_pll: assert property (p_rst_pll)
    else $error("pll controls wrong after reset");
  property p_rst_cgen;
    $rose(NRST) |-> cg_o == 4'h4;
  endproperty
  a_rst_cgen: assert property (p_rst_cgen)
    else $error("clock generator controls wrong after reset");
  property p_rst_core;
    !$past(NRST) |-> core_o == 6'h00;
  endproperty
  a_rst_core: assert property (p_rst_core)
    else $error("core controls wrong after reset");
  property p_idle_holds;
    idle_r >= 4'h8 |-> $stable(holds);
  endproperty
  a_idle_holds: assert property (p_idle_holds)
    else $error("hold changed with port idle");
  property p_idle_ctl;
    idle_r >= 4'h8 |-> $stable({pll_o, cg_o, core_o});
  endproperty
  a_idle_ctl: assert property (p_idle_ctl)
    else $error("control changed with port idle");
  property p_idle_miso;
    SPI_SEL_N [*8] |-> SPI_MISO == 1'b0;
  endproperty
  a_idle_miso: assert property (p_idle_miso)
    else $error("readback driven while deselected");
  c_hold_off: cover property ($fell(PLL_RST_HOLD));
  c_src_lvds: cover property ($fell(CLK_SRC_PLL));
  c_readback: cover property ($rose(SPI_MISO));
endmodule
bind sscr_top sscr_top_chk sscr_top_chk_inst (.SYS_CLK, .NRST, .SPI_SEL_N,
  .SPI_MISO, .PLL_RST_HOLD, .PLL_LOCK_RST_HOLD, .CGEN_RST_HOLD,
  .MUX_RST_HOLD, .AFE_RST_HOLD, .SER_RST_HOLD, .PLL_PWR_ON, .PLL_ENABLE,
  .PLL_BYPASS, .CLKIN_PWR_ON, .ANA_CLK_EN, .LOGIC_CLK_EN, .CLK_SRC_PLL,
  .ADC_8BIT, .LOGIC_EN, .IMC_PWR_ON, .MUX_PWR_ON, .COLBIAS_EN,
  .PART_VARIANT);
`default_nettype wire

// [testbench/sscr_top_tb.sv]
// Self-checking bench for the system control register bank
`timescale 1ns/1ps
`default_nettype none
module sscr_top_tb;
  // Half period of the serial clock, above the 8 cycle floor
  localparam int HP = 9;
  // Arbitrary identification value
  localparam logic [15:0] ID = 16'h5A3C;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic sck = 1'b0;
  logic sel_n = 1'b1;
  logic mosi = 1'b0;
  logic lock_in = 1'b0;
  logic miso;
  logic [5:0] holds;
  logic [3:0] pll_o;
  logic [3:0] cg_o;
  logic [3:0] core_o;
  logic [1:0] pv;
  logic [15:0] r;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  logic [8:0] ra [16] = '{9'h000, 9'h001, 9'h002, 9'h008, 9'h009, 9'h00A,
    9'h010, 9'h011, 9'h014, 9'h018, 9'h01A, 9'h01B, 9'h020, 9'h022,
    9'h028, 9'h1FF};
  logic [15:0] rv [16] = '{ID, 16'h0000, 16'h0000, 16'h0099, 16'h0009,
    16'h0999, 16'h0004, 16'h2113, 16'h0000, 16'h0000, 16'h2182, 16'h3D2D,
    16'h0004, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] mv [16] = '{ID, 16'h0000, 16'h0003, 16'h00FF, 16'h000F,
    16'h0FFF, 16'h0007, 16'h2113, 16'h0701, 16'h0000, 16'h2182, 16'h3D2D,
    16'h7F0F, 16'h0001, 16'h0007, 16'h0000};
  logic [3:0] hc [5] = '{4'h0, 4'h8, 4'h9, 4'hA, 4'hF};

  always #2.5 sys_clk = ~sys_clk;

  sscr_top #(.IDENT(ID)) sscr_top_inst (
    .SYS_CLK(sys_clk), .NRST(nrst), .SPI_SCK(sck), .SPI_SEL_N(sel_n),
    .SPI_MOSI(mosi), .SPI_MISO(miso), .PLL_LOCK_IN(lock_in),
    .PLL_RST_HOLD(holds[0]), .PLL_LOCK_RST_HOLD(holds[1]),
    .CGEN_RST_HOLD(holds[2]), .MUX_RST_HOLD(holds[3]),
    .AFE_RST_HOLD(holds[4]), .SER_RST_HOLD(holds[5]),
    .PLL_PWR_ON(pll_o[0]), .PLL_ENABLE(pll_o[1]), .PLL_BYPASS(pll_o[2]),
    .CLKIN_PWR_ON(pll_o[3]), .ANA_CLK_EN(cg_o[0]), .LOGIC_CLK_EN(cg_o[1]),
    .CLK_SRC_PLL(cg_o[2]), .ADC_8BIT(cg_o[3]), .LOGIC_EN(core_o[3]),
    .IMC_PWR_ON(core_o[0]), .MUX_PWR_ON(core_o[1]),
    .COLBIAS_EN(core_o[2]), .PART_VARIANT(pv)
  );

  task automatic chk(input string n, input logic [15:0] s,
      input logic [15:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  // One frame: address, direction, word; cut stops it early
  task automatic xfer(input logic [8:0] a, input logic d,
      input logic [15:0] w, input int cut);
    logic [25:0] f;
    f = {a, d, w};
    r = 16'h0000;
    sel_n <= 1'b0;
    for (int i = 0; i < cut; i++) begin
      mosi <= f[25-i];
      repeat (HP) @(posedge sys_clk);
      if (i > 9) r = {r[14:0], miso};
      sck <= 1'b1;
      repeat (HP) @(posedge sys_clk);
      sck <= 1'b0;
    end
    repeat (HP) @(posedge sys_clk);
    sel_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [8:0] a, input logic [15:0] w);
    xfer(a, 1'b1, w, 26);
  endtask

  task automatic rd(input logic [8:0] a);
    xfer(a, 1'b0, 16'h0000, 26);
  endtask

  task automatic outs(input logic [5:0] h, input logic [3:0] p,
      input logic [3:0] c, input logic [3:0] k, input logic [1:0] v);
    chk("holds", 16'(holds), 16'(h));
    chk("pll", 16'(pll_o), 16'(p));
    chk("cgen", 16'(cg_o), 16'(c));
    chk("core", 16'(core_o), 16'(k));
    chk("variant", 16'(pv), 16'(v));
  endtask

  task automatic do_rst();
    nrst <= 1'b0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    outs(6'h3F, 4'h4, 4'h4, 4'h0, 2'h0);
  endtask

  task automatic test_done();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, well above the length of the sequence
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail = n_fail + 1;
      test_done();
    end
  end

  initial begin
    do_rst();
    for (int i = 0; i < 16; i++) begin
      rd(ra[i]);
      chk("reset read", r, rv[i]);
    end
    // Aborted write must leave nothing behind
    xfer(9'h022, 1'b1, 16'h0001, 20);
    rd(9'h022);
    chk("cut frame", r, 16'h0000);
    // PLL and lock detector reserved words get their defaults back, others all ones
    for (int i = 0; i < 16; i++) begin
      wr(ra[i], (i == 7 || i == 10 || i == 11) ? rv[i] : 16'hFFFF);
      rd(ra[i]);
      chk("masked read", r, mv[i]);
    end
    outs(6'h00, 4'hF, 4'hF, 4'hF, 2'h3);
    do_rst();
    foreach (hc[i]) begin
      wr(9'h008, {8'h00, hc[i], hc[i]});
      wr(9'h009, {12'h000, hc[i]});
      wr(9'h00A, {4'h0, hc[i], hc[i], hc[i]});
      chk("hold code", 16'(holds), hc[i] == 4'h9 ? 16'h3F : 16'h0);
    end
    wr(9'h008, 16'h0090);
    wr(9'h00A, 16'h0090);
    chk("hold fields", 16'(holds), 16'h0012);
    for (int b = 0; b < 4; b++) begin
      wr(9'h020, 16'(1 << b));
      chk("cgen bit", 16'(cg_o), 16'(1 << b));
      wr(9'h010, 16'(1 << b));
      chk("pll bit", 16'(pll_o[2:0]), 16'(1 << b) & 16'h0007);
      wr(9'h028, 16'(1 << b));
      chk("core bit", 16'(core_o[2:0]), 16'(1 << b) & 16'h7);
      wr(9'h002, 16'(b));
      chk("variant", 16'(pv), 16'(b));
    end
    lock_in <= 1'b1;
    repeat (8) @(posedge sys_clk);
    wr(9'h018, 16'h0000);
    rd(9'h018);
    chk("lock set", r, 16'h0001);
    lock_in <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rd(9'h018);
    chk("lock clear", r, 16'h0000);
    test_done();
  end
endmodule
`default_nettype wire
